// ### hw/ifsw_top.sv
// identify words 85 to 90 and 93 with their control registers and read port
//
// How it works
// RULE_01: word 85 shows enabled command and feature bits
// RULE_02: word 85 bit 1 follows security password enable
// RULE_03: word 85 bit 10 shows protected area enabled
// RULE_04: word 85 unused bits always read zero
// RULE_05: word 86 fixed ones at 13,12,10,8
// RULE_06: word 86 low five bits read zero
// RULE_07: word 87 shows only validity bit set
// RULE_08: word 88 one hot selected ultra dma mode
// RULE_09: word 88 low bits show supported modes
// RULE_10: normal erase time coded in two minute steps
// RULE_11: enhanced erase time uses same coding
// RULE_12: reset result bits change only during reset
// RULE_13: word 93 bit 15 zero, bit 14 one
// RULE_14: bit 13 records sampled cable detect level
// RULE_15: device 1 result in 12-8, else cleared
// RULE_16: device 1 bit 11 shows own diag assert
// RULE_17: two bit method field shows numbering source
// RULE_18: device 0 result in 7-0, else cleared
// RULE_19: device 0 bit 6 responds for device 1
// RULE_20: device 0 bit 3 diag pass, bit 0 one
// RULE_21: only supported features may become enabled
// RULE_22: words assembled live, read by word number
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "ifsw_cfg.svh"
module ifsw_top #(
	parameter logic [2:0] UDMA_MAX = `IFSW_UDMA_MAX_RST
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [`IFSW_ADDR_W-1:0]  addr,
	input  wire logic [`IFSW_DATA_W-1:0]  wdata,
	input  wire logic                     wr,
	input  wire logic                     rd,
	output logic      [`IFSW_DATA_W-1:0]  rdata_r,
	input  wire logic                     sec_pw_set,
	input  wire logic                     sec_disable,
	input  wire logic                     hrst_active,
	input  wire ifsw_pkg::ifsw_hrst_in_t  hrst_in
);
	import ifsw_pkg::*;

	logic [15:0] feat_r;
	logic        sec_r;
	ifsw_udma_t  udma_r;
	logic [7:0]  erase_norm_r;
	logic [7:0]  erase_enh_r;
	logic        hrst_seen_r;
	logic [15:0] w85;
	logic [15:0] w87;
	logic [15:0] w88;
	logic [15:0] w93;
	logic [15:0] rdata_nxt;
	logic [2:0]  udma_max;
	// a literal cannot be bit-selected, so the support mask gets a name
	localparam logic [15:0] W85_SUP = `IFSW_W85_SUP_MASK;

	// minutes to erase time code, rounding up to the next two minutes
	function automatic logic [7:0] erase_code(input logic [15:0] minutes);
		logic [16:0] half;
		half = ({1'b0, minutes} + 17'h00001) >> 1;
		if (minutes == 16'h0000)
			erase_code = 8'h00;
		else if (minutes > `IFSW_ERASE_MAX_MIN)
			erase_code = `IFSW_ERASE_OVER;
		else
			erase_code = half[7:0];
	endfunction : erase_code

	assign udma_max = UDMA_MAX;

	// feature enables; unsupported bits never stick
	always_ff @(posedge clk) begin
		if (rst)
			feat_r <= `IFSW_FEAT_RST;
		else if (wr && addr == `IFSW_OFF_FEAT_CTRL)
			feat_r <= wdata & `IFSW_W85_WR_MASK; // RULE_21
	end

	// set wins so a password set in the disable cycle is kept
	always_ff @(posedge clk) begin
		if (rst)
			sec_r <= 1'b0;
		else if (sec_pw_set && W85_SUP[`IFSW_W85_SEC])
			sec_r <= 1'b1; // RULE_02
		else if (sec_disable)
			sec_r <= 1'b0;
	end

	// modes above the supported maximum are refused, old selection kept
	always_ff @(posedge clk) begin
		if (rst) begin
			udma_r.sel_valid <= 1'b0;
			udma_r.mode      <= `IFSW_UDMA_MODE_RST;
		end else if (wr && addr == `IFSW_OFF_UDMA_CTRL) begin
			if (!wdata[3] || wdata[2:0] <= udma_max) begin
				udma_r.sel_valid <= wdata[3];
				udma_r.mode      <= wdata[2:0]; // RULE_21
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			erase_norm_r <= `IFSW_ERASE_RST;
		else if (wr && addr == `IFSW_OFF_ERASE_NORM)
			erase_norm_r <= erase_code(wdata); // RULE_10
	end

	always_ff @(posedge clk) begin
		if (rst)
			erase_enh_r <= `IFSW_ERASE_RST;
		else if (wr && addr == `IFSW_OFF_ERASE_ENH)
			erase_enh_r <= erase_code(wdata); // RULE_11
	end

	// tells software that word 93 has been filled at least once
	always_ff @(posedge clk) begin
		if (rst)
			hrst_seen_r <= 1'b0;
		else if (hrst_active)
			hrst_seen_r <= 1'b1;
	end

	always_comb begin
		w85 = feat_r & `IFSW_W85_WR_MASK; // RULE_01 RULE_03
		w85[`IFSW_W85_SEC] = sec_r; // RULE_02
		w85 = w85 & `IFSW_W85_SUP_MASK; // RULE_04
	end

	always_comb begin
		w87 = 16'h0000;
		w87[`IFSW_W87_VALID_BIT] = 1'b1; // RULE_07
	end

	ifsw_udma #(
		.MODES(`IFSW_UDMA_MODES)
	) u_udma (
		.udma     (udma_r),
		.max_mode (udma_max),
		.word     (w88)
	);

	ifsw_rstres u_rstres (
		.clk         (clk),
		.rst         (rst),
		.hrst_active (hrst_active),
		.hin         (hrst_in),
		.word        (w93)
	);

	// read mux; unmapped addresses answer zero
	always_comb begin
		rdata_nxt = 16'h0000;
		if (rd) begin
			unique case (addr)
				`IFSW_OFF_FEAT_CTRL:  rdata_nxt = feat_r;
				`IFSW_OFF_UDMA_CTRL:  rdata_nxt = {12'h000, udma_r};
				`IFSW_OFF_ERASE_NORM: rdata_nxt = {8'h00, erase_norm_r};
				`IFSW_OFF_ERASE_ENH:  rdata_nxt = {8'h00, erase_enh_r};
				`IFSW_OFF_STATUS:     rdata_nxt = {14'h0000, hrst_seen_r, sec_r};
				`IFSW_OFF_W85:        rdata_nxt = w85; // RULE_22
				`IFSW_OFF_W86:        rdata_nxt = `IFSW_W86_VAL; // RULE_05 RULE_06
				`IFSW_OFF_W87:        rdata_nxt = w87;
				`IFSW_OFF_W88:        rdata_nxt = w88;
				`IFSW_OFF_W89:        rdata_nxt = {8'h00, erase_norm_r};
				`IFSW_OFF_W90:        rdata_nxt = {8'h00, erase_enh_r};
				`IFSW_OFF_W93:        rdata_nxt = w93;
				default:              rdata_nxt = 16'h0000;
			endcase
		end
	end

	// data stand for one cycle only, zero otherwise
	always_ff @(posedge clk) begin
		if (rst)
			rdata_r <= 16'h0000;
		else
			rdata_r <= rdata_nxt; // RULE_22
	end

	AST_RD_IDLE: assert property (@(posedge clk) disable iff (rst) // RULE_22
		!rd |=> rdata_r == 16'h0000)
		else $error("read data present without a read");

	AST_W85_FEAT: assert property (@(posedge clk) disable iff (rst) // RULE_01
		rd && addr == `IFSW_OFF_W85 |=>
			rdata_r[`IFSW_W85_NOP] == $past(feat_r[`IFSW_W85_NOP])
			&& rdata_r[`IFSW_W85_LOOKAHEAD] == $past(feat_r[`IFSW_W85_LOOKAHEAD])
			&& rdata_r[`IFSW_W85_WCACHE] == $past(feat_r[`IFSW_W85_WCACHE])
			&& rdata_r[`IFSW_W85_PM] == $past(feat_r[`IFSW_W85_PM]))
		else $error("word 85 feature bits do not follow enables");

	AST_W85_SEC: assert property (@(posedge clk) disable iff (rst) // RULE_02
		sec_pw_set ##1 (!sec_disable) [*2] ##0 (rd && addr == `IFSW_OFF_W85)
			|=> rdata_r[`IFSW_W85_SEC])
		else $error("security enable not reported");

	AST_W85_HPA: assert property (@(posedge clk) disable iff (rst) // RULE_03
		wr && addr == `IFSW_OFF_FEAT_CTRL ##1 !wr ##1 (rd && addr == `IFSW_OFF_W85)
			|=> rdata_r[`IFSW_W85_HPA] == $past(wdata[`IFSW_W85_HPA], 3))
		else $error("protected area bit does not follow its enable");

	AST_W85_ZERO: assert property (@(posedge clk) disable iff (rst) // RULE_04
		rd && addr == `IFSW_OFF_W85 |=> (rdata_r & ~`IFSW_W85_SUP_MASK) == 16'h0000)
		else $error("word 85 reserved bit set");

	AST_W86: assert property (@(posedge clk) disable iff (rst) // RULE_06
		rd && addr == `IFSW_OFF_W86 |=> rdata_r == 16'h3500 && rdata_r[4:0] == 5'h00)
		else $error("word 86 wrong");

	AST_W87: assert property (@(posedge clk) disable iff (rst) // RULE_07
		rd && addr == `IFSW_OFF_W87 |=> !rdata_r[15] && $onehot(rdata_r))
		else $error("word 87 wrong");

	AST_W88_SEL: assert property (@(posedge clk) disable iff (rst) // RULE_08
		$onehot0(w88[14:8])
			&& (!udma_r.sel_valid || w88[`IFSW_UDMA_SEL_LSB + udma_r.mode]))
		else $error("ultra dma selection not one hot on the mode");

	AST_W88_SUP: assert property (@(posedge clk) disable iff (rst) // RULE_09
		((w88[6:0] + 7'h01) & w88[6:0]) == 7'h00 && w88[0])
		else $error("ultra dma support field not a thermometer");

	AST_UDMA_REFUSE: assert property (@(posedge clk) disable iff (rst) // RULE_21
		wr && addr == `IFSW_OFF_UDMA_CTRL && wdata[3] && wdata[2:0] > udma_max
			|=> $stable(udma_r))
		else $error("unsupported ultra dma mode accepted");

	AST_ERASE_OVER: assert property (@(posedge clk) disable iff (rst) // RULE_10
		wr && addr == `IFSW_OFF_ERASE_NORM && wdata > 16'h01fc
			|=> erase_norm_r == 8'hff)
		else $error("long erase time not coded as 255");

	AST_ERASE_ENH: assert property (@(posedge clk) disable iff (rst) // RULE_11
		wr && addr == `IFSW_OFF_ERASE_ENH && wdata != 16'h0000 && wdata <= 16'h01fc
			|=> erase_enh_r != 8'h00 && erase_enh_r != 8'hff
			&& {erase_enh_r, 1'b0} >= $past(wdata[8:0]))
		else $error("enhanced erase time coded wrong");

	AST_W93_FIXED: assert property (@(posedge clk) disable iff (rst) // RULE_13
		rd && addr == `IFSW_OFF_W93 |=> rdata_r[15:14] == 2'b01)
		else $error("word 93 fixed bits wrong");

	AST_W93_CBLID: assert property (@(posedge clk) disable iff (rst) // RULE_14
		hrst_active ##1 !hrst_active [*2] |-> w93[13] == $past(hrst_in.cblid, 2))
		else $error("cable detect level not held");

	AST_W93_PDIAG: assert property (@(posedge clk) disable iff (rst) // RULE_16
		hrst_active && hrst_in.dev1 |=> w93[11] == $past(hrst_in.pdiag_out)
			&& w93[10:9] == $past(hrst_in.devnum_method))
		else $error("device 1 diag or method wrong");

	AST_W93_RESP: assert property (@(posedge clk) disable iff (rst) // RULE_19
		hrst_active && !hrst_in.dev1 |=> w93[6] == $past(hrst_in.resp_dev1)
			&& w93[2:1] == $past(hrst_in.devnum_method) && w93[0])
		else $error("device 0 response bit wrong");

	// end to end: a feature write shows up in word 85
	AST_W85_WRITE: assert property (@(posedge clk) disable iff (rst) // RULE_01
		wr && addr == `IFSW_OFF_FEAT_CTRL ##1 !wr ##1 (rd && addr == `IFSW_OFF_W85)
			|=> (rdata_r & `IFSW_W85_WR_MASK) == ($past(wdata, 3) & `IFSW_W85_WR_MASK))
		else $error("word 85 does not follow the feature write");

	AST_SEC_SET: assert property (@(posedge clk) disable iff (rst) // RULE_02
		sec_pw_set |=> sec_r)
		else $error("security enable not set by password");

	AST_SEC_CLEAR: assert property (@(posedge clk) disable iff (rst) // RULE_02
		sec_disable && !sec_pw_set |=> !sec_r)
		else $error("security enable not cleared");

	AST_FEAT_MASK: assert property (@(posedge clk) disable iff (rst) // RULE_21
		(feat_r & ~`IFSW_W85_WR_MASK) == 16'h0000)
		else $error("unsupported feature held as enabled");

	AST_CTRL_READ: assert property (@(posedge clk) disable iff (rst) // RULE_21
		rd && addr == `IFSW_OFF_FEAT_CTRL |=> (rdata_r & ~`IFSW_W85_WR_MASK) == 16'h0000)
		else $error("feature control read shows unsupported bits");

	AST_UDMA_TAKE: assert property (@(posedge clk) disable iff (rst) // RULE_08
		wr && addr == `IFSW_OFF_UDMA_CTRL && wdata[3] && wdata[2:0] <= udma_max
			|=> w88[14:8] == (7'h01 << $past(wdata[2:0])))
		else $error("supported ultra dma mode not selected");

	AST_UDMA_OFF: assert property (@(posedge clk) disable iff (rst) // RULE_08
		wr && addr == `IFSW_OFF_UDMA_CTRL && !wdata[3]
			|=> w88[14:8] == 7'h00)
		else $error("ultra dma selection left set");

	AST_UDMA_READ: assert property (@(posedge clk) disable iff (rst) // RULE_21
		rd && addr == `IFSW_OFF_UDMA_CTRL |=> rdata_r[15:4] == 12'h000)
		else $error("ultra dma control read has stray bits");

	// read port returns each word as it stands
	AST_W88_READ: assert property (@(posedge clk) disable iff (rst) // RULE_22
		rd && addr == `IFSW_OFF_W88 |=> rdata_r == $past(w88))
		else $error("word 88 read back wrong");

	AST_ERASE_ZERO: assert property (@(posedge clk) disable iff (rst) // RULE_10
		wr && addr == `IFSW_OFF_ERASE_NORM && wdata == 16'h0000
			|=> erase_norm_r == 8'h00)
		else $error("unspecified erase time not coded as zero");

	AST_ERASE_NORM: assert property (@(posedge clk) disable iff (rst) // RULE_10
		wr && addr == `IFSW_OFF_ERASE_NORM && wdata != 16'h0000 && wdata <= 16'h01fc
			|=> erase_norm_r != 8'h00 && erase_norm_r != 8'hff
			&& ({erase_norm_r, 1'b0} - $past(wdata[8:0])) <= 9'h001)
		else $error("normal erase time not rounded up to two minutes");

	AST_ERASE_ENH_OVER: assert property (@(posedge clk) disable iff (rst) // RULE_11
		wr && addr == `IFSW_OFF_ERASE_ENH && wdata > 16'h01fc
			|=> erase_enh_r == 8'hff)
		else $error("long enhanced erase time not coded as 255");

	AST_ERASE_ENH_ZERO: assert property (@(posedge clk) disable iff (rst) // RULE_11
		wr && addr == `IFSW_OFF_ERASE_ENH && wdata == 16'h0000
			|=> erase_enh_r == 8'h00)
		else $error("unspecified enhanced erase time not coded as zero");

	AST_W89_READ: assert property (@(posedge clk) disable iff (rst) // RULE_10
		rd && addr == `IFSW_OFF_W89 |=> rdata_r == {8'h00, $past(erase_norm_r)})
		else $error("word 89 read back wrong");

	AST_W90_READ: assert property (@(posedge clk) disable iff (rst) // RULE_11
		rd && addr == `IFSW_OFF_W90 |=> rdata_r == {8'h00, $past(erase_enh_r)})
		else $error("word 90 read back wrong");

	AST_W93_READ: assert property (@(posedge clk) disable iff (rst) // RULE_22
		rd && addr == `IFSW_OFF_W93 |=> rdata_r == $past(w93))
		else $error("word 93 read back wrong");

	AST_HRST_SEEN: assert property (@(posedge clk) disable iff (rst) // RULE_12
		hrst_active |=> hrst_seen_r)
		else $error("capture flag not set by hardware reset");

	AST_STATUS: assert property (@(posedge clk) disable iff (rst) // RULE_02
		rd && addr == `IFSW_OFF_STATUS
			|=> rdata_r[15:2] == 14'h0000 && rdata_r[0] == $past(sec_r))
		else $error("status read wrong");

endmodule : ifsw_top

// ### hw/ifsw_cfg.svh
// constants for the identify feature and status word block
`ifndef IFSW_CFG_SVH
`define IFSW_CFG_SVH

`define IFSW_DATA_W          16
`define IFSW_ADDR_W          8

// software control registers
`define IFSW_OFF_FEAT_CTRL   8'h00
`define IFSW_OFF_UDMA_CTRL   8'h01
`define IFSW_OFF_ERASE_NORM  8'h02
`define IFSW_OFF_ERASE_ENH   8'h03
`define IFSW_OFF_STATUS      8'h04

// identify words, addressed by word number
`define IFSW_OFF_W85         8'h55
`define IFSW_OFF_W86         8'h56
`define IFSW_OFF_W87         8'h57
`define IFSW_OFF_W88         8'h58
`define IFSW_OFF_W89         8'h59
`define IFSW_OFF_W90         8'h5a
`define IFSW_OFF_W93         8'h5d

// word 85 field positions
`define IFSW_W85_NOP         14
`define IFSW_W85_RBUF        13
`define IFSW_W85_WBUF        12
`define IFSW_W85_HPA         10
`define IFSW_W85_LOOKAHEAD   6
`define IFSW_W85_WCACHE      5
`define IFSW_W85_PM          3
`define IFSW_W85_SEC         1
`define IFSW_W85_SUP_MASK    16'h746a
`define IFSW_W85_WR_MASK     16'h7468
`define IFSW_FEAT_RST        16'h7408

// fixed words
`define IFSW_W86_VAL         16'h3500
`define IFSW_W87_VALID_BIT   14

// ultra dma
`define IFSW_UDMA_MODES      7
`define IFSW_UDMA_SEL_LSB    8
`define IFSW_UDMA_MAX_RST    3'h6
`define IFSW_UDMA_MODE_RST   3'h0

// erase time coding
`define IFSW_ERASE_MAX_MIN   16'h01fc
`define IFSW_ERASE_OVER      8'hff
`define IFSW_ERASE_RST       8'h00

// word 93 positions
`define IFSW_W93_RST         16'h4000
`define IFSW_W93_CBLID       13
`define IFSW_W93_D1_LSB      8
`define IFSW_W93_D0_LSB      0

`endif

// ### hw/ifsw_pkg.sv
// types shared by the identify feature and status word block
package ifsw_pkg;

	// levels sampled while the device hardware reset runs
	typedef struct packed {
		logic       cblid;
		logic       dev1;
		logic       pdiag_out;
		logic [1:0] devnum_method;
		logic       resp_dev1;
		logic       dasp_seen;
		logic       pdiag_seen;
		logic       diag_pass;
	} ifsw_hrst_in_t;

	typedef struct packed {
		logic       sel_valid;
		logic [2:0] mode;
	} ifsw_udma_t;

endpackage : ifsw_pkg

// ### hw/ifsw_udma.sv
// ultra dma selected and supported word
`timescale 1ns/10ps
`include "ifsw_cfg.svh"
module ifsw_udma #(
	parameter int MODES = `IFSW_UDMA_MODES
) (
	input  wire ifsw_pkg::ifsw_udma_t udma,
	input  wire logic [2:0]          max_mode,
	output logic [15:0]              word
);
	import ifsw_pkg::*;

	genvar gi;
	generate
		for (gi = 0; gi < MODES; gi++) begin : g_mode
			// one hot select, thermometer support
			assign word[`IFSW_UDMA_SEL_LSB + gi] = udma.sel_valid && (udma.mode == 3'(gi)); // RULE_08
			assign word[gi] = (3'(gi) <= max_mode); // RULE_09
		end
	endgenerate
	assign word[15] = 1'b0;
	assign word[7]  = 1'b0;
endmodule : ifsw_udma

// ### hw/ifsw_rstres.sv
// hardware reset result word, captured while the device reset runs
`timescale 1ns/10ps
`include "ifsw_cfg.svh"
module ifsw_rstres (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    hrst_active,
	input  wire ifsw_pkg::ifsw_hrst_in_t hin,
	output logic [15:0]                  word
);
	import ifsw_pkg::*;

	// bit 13 stored too: the cable level only means something as sampled in reset
	logic [13:0] res_r;
	logic [13:0] res_nxt;

	always_comb begin
		res_nxt = '0;
		res_nxt[`IFSW_W93_CBLID] = hin.cblid; // RULE_14
		if (hin.dev1) begin
			// device 1 half, device 0 half stays clear
			res_nxt[`IFSW_W93_D1_LSB + 3]   = hin.pdiag_out; // RULE_16
			res_nxt[`IFSW_W93_D1_LSB + 1 +: 2] = hin.devnum_method; // RULE_17
			res_nxt[`IFSW_W93_D1_LSB]       = 1'b1; // RULE_15
		end else begin
			res_nxt[`IFSW_W93_D0_LSB + 6]   = hin.resp_dev1; // RULE_19
			res_nxt[`IFSW_W93_D0_LSB + 5]   = hin.dasp_seen;
			res_nxt[`IFSW_W93_D0_LSB + 4]   = hin.pdiag_seen;
			res_nxt[`IFSW_W93_D0_LSB + 3]   = hin.diag_pass; // RULE_20
			res_nxt[`IFSW_W93_D0_LSB + 1 +: 2] = hin.devnum_method; // RULE_17
			res_nxt[`IFSW_W93_D0_LSB]       = 1'b1; // RULE_18
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			res_r <= '0;
		else if (hrst_active)
			res_r <= res_nxt; // RULE_12
	end

	assign word = `IFSW_W93_RST | {2'h0, res_r}; // RULE_13

	AST_W93_HOLD: assert property (@(posedge clk) disable iff (rst) // RULE_12
		!hrst_active |=> $stable(word[12:0]))
		else $error("reset result changed outside hardware reset");
	AST_W93_HALVES: assert property (@(posedge clk) disable iff (rst) // RULE_15
		hrst_active && hin.dev1 |=> word[7:0] == 8'h00 && word[8])
		else $error("device 1 result halves wrong");
	AST_W93_DEV0: assert property (@(posedge clk) disable iff (rst) // RULE_18
		hrst_active && !hin.dev1 |=> word[12:8] == 5'h00 && word[0]
			&& word[3] == $past(hin.diag_pass))
		else $error("device 0 result halves wrong");
endmodule : ifsw_rstres

// ### bench/ifsw_host_model.sv
// host side model that reads and writes the identify register port
`timescale 1ns/10ps
`include "ifsw_cfg.svh"
module ifsw_host_model (
	input  wire logic                    clk,
	input  wire logic [`IFSW_DATA_W-1:0] rdata_r,
	output logic      [`IFSW_ADDR_W-1:0] addr,
	output logic      [`IFSW_DATA_W-1:0] wdata,
	output logic                         wr,
	output logic                         rd
);
	initial begin
		addr  = 8'h00;
		wdata = 16'h0000;
		wr    = 1'b0;
		rd    = 1'b0;
	end

	// callers may also write unsupported feature bits (t_features writes 16'hffff); contents of word 87 never steer it
	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr    <= 1'b0;
		// idle bus shows inverted values so a stale capture is caught
		addr  <= ~a;
		wdata <= ~d;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd   <= 1'b0;
		addr <= ~a;
		// data stand only in this cycle
		@(negedge clk);
		d = rdata_r;
	endtask : read_reg
endmodule : ifsw_host_model

// ### bench/test_ifsw_top.sv
// self-checking bench for the identify feature and status words
`timescale 1ns/10ps
`include "ifsw_cfg.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_ifsw_top;
	import ifsw_pkg::*;
	logic                clk;
	logic                rst;
	logic [7:0]          addr;
	logic [15:0]         wdata;
	logic                wr;
	logic                rd;
	logic [15:0]         rdata_r;
	logic                sec_pw_set;
	logic                sec_disable;
	logic                hrst_active;
	ifsw_hrst_in_t       hrst_in;
	int                  n_mismatch = 0;
	int                  checked = 0;
	int                  cycles = 0;
	logic [15:0]         fbits [7] = '{16'h4000, 16'h2000, 16'h1000, 16'h0400,
		16'h0040, 16'h0020, 16'h0008};
	int                  mins [7] = '{0, 1, 2, 3, 508, 509, 65535};
	logic [7:0]          codes [7] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'hfe, 8'hff, 8'hff};

	ifsw_top ifsw_top_i (
		.clk         (clk),
		.rst         (rst),
		.addr        (addr),
		.wdata       (wdata),
		.wr          (wr),
		.rd          (rd),
		.rdata_r     (rdata_r),
		.sec_pw_set  (sec_pw_set),
		.sec_disable (sec_disable),
		.hrst_active (hrst_active),
		.hrst_in     (hrst_in)
	);

	ifsw_host_model ifsw_host_model_i (
		.clk     (clk),
		.rdata_r (rdata_r),
		.addr    (addr),
		.wdata   (wdata),
		.wr      (wr),
		.rd      (rd)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim

	// budget covers every scenario with wide margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk_rd(input string nm, input logic [7:0] a, input logic [15:0] ex);
		logic [15:0] d;
		ifsw_host_model_i.read_reg(a, d);
		`CHK(nm, ex, d)
	endtask : chk_rd

	task automatic t_reset_values;
		chk_rd("w85", `IFSW_OFF_W85, 16'h7408);
		chk_rd("w86", `IFSW_OFF_W86, 16'h3500);
		chk_rd("w87", `IFSW_OFF_W87, 16'h4000);
		chk_rd("w88", `IFSW_OFF_W88, 16'h007f);
		chk_rd("w89", `IFSW_OFF_W89, 16'h0000);
		chk_rd("w90", `IFSW_OFF_W90, 16'h0000);
		chk_rd("w93", `IFSW_OFF_W93, 16'h4000);
		chk_rd("feat ctrl", `IFSW_OFF_FEAT_CTRL, 16'h7408);
		chk_rd("udma ctrl", `IFSW_OFF_UDMA_CTRL, 16'h0000);
		chk_rd("status", `IFSW_OFF_STATUS, 16'h0000);
		ifsw_host_model_i.write_reg(`IFSW_OFF_W86, 16'h0000);
		chk_rd("w86 ro", `IFSW_OFF_W86, 16'h3500);
		chk_rd("unmapped", 8'h80, 16'h0000);
		$display("test reset_values done");
	endtask : t_reset_values

	task automatic t_features;
		ifsw_host_model_i.write_reg(`IFSW_OFF_FEAT_CTRL, 16'hffff);
		chk_rd("w85 all", `IFSW_OFF_W85, 16'h7468);
		for (int i = 0; i < 7; i++) begin
			ifsw_host_model_i.write_reg(`IFSW_OFF_FEAT_CTRL, fbits[i]);
			chk_rd("w85 bit", `IFSW_OFF_W85, fbits[i]);
		end
		ifsw_host_model_i.write_reg(`IFSW_OFF_FEAT_CTRL, 16'h0000);
		chk_rd("w85 none", `IFSW_OFF_W85, 16'h0000);
		$display("test features done");
	endtask : t_features

	task automatic sec_pulse(input logic s, input logic c);
		@(posedge clk);
		sec_pw_set  <= s;
		sec_disable <= c;
		@(posedge clk);
		sec_pw_set  <= 1'b0;
		sec_disable <= 1'b0;
	endtask : sec_pulse

	task automatic t_security;
		sec_pulse(1'b1, 1'b0);
		chk_rd("w85 sec", `IFSW_OFF_W85, 16'h0002);
		sec_pulse(1'b0, 1'b1);
		chk_rd("w85 sec off", `IFSW_OFF_W85, 16'h0000);
		sec_pulse(1'b1, 1'b1);
		chk_rd("w85 set wins", `IFSW_OFF_W85, 16'h0002);
		$display("test security done");
	endtask : t_security

	task automatic t_udma;
		for (int n = 0; n < 7; n++) begin
			ifsw_host_model_i.write_reg(`IFSW_OFF_UDMA_CTRL, 16'h0008 | 16'(n));
			chk_rd("w88 sel", `IFSW_OFF_W88, (16'h0100 << n) | 16'h007f);
		end
		ifsw_host_model_i.write_reg(`IFSW_OFF_UDMA_CTRL, 16'h000f);
		chk_rd("w88 over", `IFSW_OFF_W88, 16'h407f);
		chk_rd("udma ctrl kept", `IFSW_OFF_UDMA_CTRL, 16'h000e);
		ifsw_host_model_i.write_reg(`IFSW_OFF_UDMA_CTRL, 16'h0005);
		chk_rd("w88 off", `IFSW_OFF_W88, 16'h007f);
		$display("test udma done");
	endtask : t_udma

	task automatic t_erase;
		for (int i = 0; i < 7; i++) begin
			ifsw_host_model_i.write_reg(`IFSW_OFF_ERASE_NORM, 16'(mins[i]));
			ifsw_host_model_i.write_reg(`IFSW_OFF_ERASE_ENH, 16'(mins[6 - i]));
			chk_rd("w89", `IFSW_OFF_W89, {8'h00, codes[i]});
			chk_rd("w90", `IFSW_OFF_W90, {8'h00, codes[6 - i]});
			chk_rd("norm code", `IFSW_OFF_ERASE_NORM, {8'h00, codes[i]});
			chk_rd("enh code", `IFSW_OFF_ERASE_ENH, {8'h00, codes[6 - i]});
		end
		$display("test erase done");
	endtask : t_erase

	task automatic hrst_run(input ifsw_hrst_in_t v, input logic act);
		@(posedge clk);
		hrst_active <= act;
		hrst_in     <= v;
		@(posedge clk);
		hrst_active <= 1'b0;
	endtask : hrst_run

	task automatic t_hrst;
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			hrst_run({1'b1, 1'b0, 1'b0, m, 1'b1, 1'b1, 1'b0, 1'b1}, 1'b1);
			chk_rd("w93 dev0", `IFSW_OFF_W93, 16'h6069 | {13'h0, m, 1'b0});
			hrst_run({1'b0, 1'b1, 1'b1, m, 1'b1, 1'b1, 1'b1, 1'b1}, 1'b1);
			chk_rd("w93 dev1", `IFSW_OFF_W93, 16'h4900 | {5'h0, m, 9'h0});
		end
		hrst_run({1'b1, 1'b1, 1'b0, 2'b01, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b1);
		chk_rd("w93 no pdiag", `IFSW_OFF_W93, 16'h6300);
		hrst_run({1'b0, 1'b0, 1'b0, 2'b11, 1'b0, 1'b0, 1'b1, 1'b0}, 1'b0);
		chk_rd("w93 hold", `IFSW_OFF_W93, 16'h6300);
		hrst_run({1'b0, 1'b0, 1'b0, 2'b10, 1'b0, 1'b0, 1'b1, 1'b0}, 1'b1);
		chk_rd("w93 fail", `IFSW_OFF_W93, 16'h4015);
		chk_rd("status", `IFSW_OFF_STATUS, 16'h0003);
		$display("test hrst done");
	endtask : t_hrst

	initial begin
		rst         = 1'b1;
		sec_pw_set  = 1'b0;
		sec_disable = 1'b0;
		hrst_active = 1'b0;
		hrst_in     = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset_values();
		t_features();
		t_security();
		t_udma();
		t_erase();
		t_hrst();
		end_sim();
	end
endmodule : test_ifsw_top
